// [common/arb_host_pkg.sv]
// constants and state encodings for the priority-arbitration host side
package arb_host_pkg;

  localparam int unsigned CLOCK_MHZ  = 250;
  localparam int unsigned DESKEW_NS  = 75;
  // least time, rounded up to whole clock periods
  localparam int unsigned DESKEW_CYC = (DESKEW_NS * CLOCK_MHZ + 999) / 1000;
  localparam int unsigned CNT_W      = 5;
  localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
  localparam logic [CNT_W-1:0] CNT_ONE  = 5'h01;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(DESKEW_CYC - 1);
  localparam int unsigned VEC_W      = 16;
  localparam logic [VEC_W-1:0] VEC_ZERO = 16'h0000;

  typedef enum logic [2:0] {
    M_IDLE      = 3'b000,
    M_REQ       = 3'b001,
    M_BUSY_WAIT = 3'b010,
    M_SYNC_WAIT = 3'b011,
    M_REPLY     = 3'b100,
    M_DROP      = 3'b101,
    M_TAIL      = 3'b110
  } master_state_e;

  typedef enum logic [1:0] {
    F_IDLE   = 2'b00,
    F_DESKEW = 2'b01,
    F_HOLD   = 2'b10,
    F_AUTH   = 2'b11
  } fielder_state_e;

endpackage : arb_host_pkg

// [hdl/arb_host.sv]
// interrupting bus master and interrupt fielding processor for the arbiter
// Overview of operation
// - requester answers grant with acknowledge and drops its request in the same clock.
// - a far-end terminator may acknowledge grants to avoid the timeout.
// - acknowledged requester waits for bus-busy low, then asserts it.
// - only a level-granted master may drive an interrupt vector.
// - master raises interrupt strobe only with slave-sync seen low.
// - acknowledge drops only after strobe raised and grant seen removed.
// - if strobe already done, acknowledge drops once grant removal seen.
// - processor waits 75 ns on strobe, latches vector, sets slave-sync.
// - on slave-sync: remove vector, then drop strobe, then bus-busy.
// - processor drops slave-sync when the strobe is seen negated.
// - processor signals level grants allowed after its new level is set.
// - at most one interrupt transaction per level grant.
// - master waits 75 ns after its last strobe before releasing bus-busy.
// - acknowledge is negated before bus-busy is negated.
// - release without interrupt is passive; transfers as direct master.
`timescale 1ns/1ps
module arb_host (
  input  wire logic                           clock_i,
  input  wire logic                           rst_n_i,
  // user side of the interrupting master
  input  wire logic                           irq_start_i,
  input  wire logic [arb_host_pkg::VEC_W-1:0] irq_vector_i,
  output logic                                irq_busy_o,
  output logic                                irq_done_o,
  // user side of the fielding processor
  input  wire logic                           level_set_i,
  output logic [arb_host_pkg::VEC_W-1:0]      fielded_vector_o,
  output logic                                fielded_valid_o,
  output logic                                level_grant_enable_o,
  // bus lines, open drain
  input  wire logic                           level_grant_i,
  input  wire logic                           level_request_i,
  output logic                                level_request_o,
  output logic                                level_request_oe_n_o,
  input  wire logic                           selection_acknowledge_i,
  output logic                                selection_acknowledge_o,
  output logic                                selection_acknowledge_oe_n_o,
  input  wire logic                           bus_busy_i,
  output logic                                bus_busy_o,
  output logic                                bus_busy_oe_n_o,
  input  wire logic                           interrupt_strobe_i,
  output logic                                interrupt_strobe_o,
  output logic                                interrupt_strobe_oe_n_o,
  input  wire logic                           slave_sync_i,
  output logic                                slave_sync_o,
  output logic                                slave_sync_oe_n_o,
  input  wire logic [arb_host_pkg::VEC_W-1:0] data_i,
  output logic [arb_host_pkg::VEC_W-1:0]      data_o,
  output logic                                data_oe_n_o
);

  typedef struct packed {
    arb_host_pkg::master_state_e    m_state;
    logic [arb_host_pkg::CNT_W-1:0] m_cnt;
    logic                           lreq;
    logic                           ack;
    logic                           busy;
    logic                           strobe;
    logic                           drive;
    logic                           strobe_sent;
    logic                           done;
    logic [arb_host_pkg::VEC_W-1:0] vector;
    arb_host_pkg::fielder_state_e   f_state;
    logic [arb_host_pkg::CNT_W-1:0] f_cnt;
    logic                           sync;
    logic                           grant_en;
    logic                           f_valid;
    logic [arb_host_pkg::VEC_W-1:0] f_vector;
  } host_state_s;

  host_state_s s_q;
  host_state_s s_d;

  always_comb begin
    s_d       = s_q;
    s_d.done  = 1'b0;
    s_d.f_valid = 1'b0;

    // interrupting master
    case (s_q.m_state)
      arb_host_pkg::M_IDLE: begin
        if (irq_start_i) begin
          s_d.vector      = irq_vector_i;
          s_d.lreq        = 1'b1;
          s_d.strobe_sent = 1'b0;
          s_d.m_state     = arb_host_pkg::M_REQ;
        end
      end
      arb_host_pkg::M_REQ: begin
        // grant lost to timeout: keep requesting
        if (level_grant_i) begin
          s_d.ack     = 1'b1;
          s_d.lreq    = 1'b0;
          s_d.m_state = arb_host_pkg::M_BUSY_WAIT;
        end
      end
      arb_host_pkg::M_BUSY_WAIT: begin
        if (!bus_busy_i) begin
          s_d.busy    = 1'b1;
          s_d.drive   = 1'b1;
          s_d.m_state = arb_host_pkg::M_SYNC_WAIT;
        end
      end
      arb_host_pkg::M_SYNC_WAIT: begin
        if (!slave_sync_i && !s_q.strobe_sent) begin
          s_d.strobe      = 1'b1;
          s_d.strobe_sent = 1'b1;
          s_d.m_state   = arb_host_pkg::M_REPLY;
        end
      end
      arb_host_pkg::M_REPLY: begin
        if (slave_sync_i) begin
          s_d.drive   = 1'b0;
          s_d.m_state = arb_host_pkg::M_DROP;
        end
      end
      arb_host_pkg::M_DROP: begin
        s_d.strobe  = 1'b0;
        s_d.m_cnt   = arb_host_pkg::CNT_ZERO;
        s_d.m_state = arb_host_pkg::M_TAIL;
      end
      arb_host_pkg::M_TAIL: begin
        if (s_q.m_cnt != arb_host_pkg::CNT_LAST) begin
          s_d.m_cnt = s_q.m_cnt + arb_host_pkg::CNT_ONE;
        end else if (!s_q.ack) begin
          s_d.busy    = 1'b0;
          s_d.done    = 1'b1;
          s_d.m_state = arb_host_pkg::M_IDLE;
        end
      end
      default: begin
        s_d.m_state = arb_host_pkg::M_IDLE;
      end
    endcase

    // acknowledge release: strobe done and grant seen removed
    if (s_q.ack && s_q.strobe_sent && !level_grant_i) begin
      s_d.ack = 1'b0;
    end

    // interrupt fielding processor
    case (s_q.f_state)
      arb_host_pkg::F_IDLE: begin
        if (interrupt_strobe_i) begin
          s_d.grant_en = 1'b0;
          s_d.f_cnt    = arb_host_pkg::CNT_ZERO;
          s_d.f_state  = arb_host_pkg::F_DESKEW;
        end
      end
      arb_host_pkg::F_DESKEW: begin
        if (s_q.f_cnt != arb_host_pkg::CNT_LAST) begin
          s_d.f_cnt = s_q.f_cnt + arb_host_pkg::CNT_ONE;
        end else begin
          s_d.f_vector = data_i;
          s_d.f_valid  = 1'b1;
          s_d.sync     = 1'b1;
          s_d.f_state  = arb_host_pkg::F_HOLD;
        end
      end
      arb_host_pkg::F_HOLD: begin
        if (!interrupt_strobe_i) begin
          s_d.sync    = 1'b0;
          s_d.f_state = arb_host_pkg::F_AUTH;
        end
      end
      arb_host_pkg::F_AUTH: begin
        if (level_set_i) begin
          s_d.grant_en = 1'b1;
          s_d.f_state  = arb_host_pkg::F_IDLE;
        end
      end
      default: begin
        s_d.f_state = arb_host_pkg::F_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q.m_state   <= arb_host_pkg::M_IDLE;
      s_q.m_cnt     <= arb_host_pkg::CNT_ZERO;
      s_q.lreq      <= 1'b0;
      s_q.ack         <= 1'b0;
      s_q.busy        <= 1'b0;
      s_q.strobe      <= 1'b0;
      s_q.drive       <= 1'b0;
      s_q.strobe_sent <= 1'b0;
      s_q.done      <= 1'b0;
      s_q.vector    <= arb_host_pkg::VEC_ZERO;
      s_q.f_state   <= arb_host_pkg::F_IDLE;
      s_q.f_cnt     <= arb_host_pkg::CNT_ZERO;
      s_q.sync      <= 1'b0;
      s_q.grant_en  <= 1'b1;
      s_q.f_valid   <= 1'b0;
      s_q.f_vector  <= arb_host_pkg::VEC_ZERO;
    end else begin
      s_q <= s_d;
    end
  end

  assign irq_busy_o                   = (s_q.m_state != arb_host_pkg::M_IDLE);
  assign irq_done_o                   = s_q.done;
  assign fielded_vector_o             = s_q.f_vector;
  assign fielded_valid_o              = s_q.f_valid;
  assign level_grant_enable_o         = s_q.grant_en;
  assign level_request_o              = s_q.lreq;
  assign level_request_oe_n_o         = !s_q.lreq;
  assign selection_acknowledge_o      = s_q.ack;
  assign selection_acknowledge_oe_n_o = !s_q.ack;
  assign bus_busy_o                   = s_q.busy;
  assign bus_busy_oe_n_o              = !s_q.busy;
  assign interrupt_strobe_o           = s_q.strobe;
  assign interrupt_strobe_oe_n_o      = !s_q.strobe;
  assign slave_sync_o                 = s_q.sync;
  assign slave_sync_oe_n_o            = !s_q.sync;
  assign data_o                       = s_q.drive ? s_q.vector
                                                  : arb_host_pkg::VEC_ZERO;
  assign data_oe_n_o                  = !s_q.drive;

  // checks
  sequence vec_removed_s;
    !s_q.drive && s_q.strobe;
  endsequence

  sequence strobe_dropped_s;
    !s_q.drive && !s_q.strobe;
  endsequence

  a_ack_on_grant: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (s_q.m_state == arb_host_pkg::M_REQ && level_grant_i)
      |=> s_q.ack && !s_q.lreq)
    else $error("acknowledge not raised on grant");

  a_ack_release: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $fell(s_q.ack) |-> $past(s_q.strobe_sent) && !$past(level_grant_i))
    else $error("acknowledge dropped too early");

  a_busy_take: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $rose(s_q.busy) |-> !$past(bus_busy_i) && s_q.ack)
    else $error("bus-busy taken while bus busy");

  a_vector_master: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    s_q.drive |-> s_q.busy)
    else $error("vector driven without mastership");

  a_strobe_start: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $rose(s_q.strobe) |-> !$past(slave_sync_i) && s_q.drive)
    else $error("strobe raised with slave-sync high");

  a_reply_order: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (s_q.m_state == arb_host_pkg::M_REPLY && slave_sync_i)
      |=> vec_removed_s ##1 strobe_dropped_s)
    else $error("vector and strobe released out of order");

  a_ack_before_busy: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $fell(s_q.busy) |-> !$past(s_q.ack))
    else $error("bus-busy dropped before acknowledge");

  a_one_strobe: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $rose(s_q.strobe) |-> !$past(s_q.strobe_sent))
    else $error("second interrupt under one grant");

  a_vec_deskew: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (s_q.f_state == arb_host_pkg::F_IDLE && interrupt_strobe_i)
      |=> (!s_q.sync) [*8] ##11 (!s_q.sync)
          ##1 (s_q.sync && s_q.f_valid))
    else $error("slave-sync deskew wrong");

  a_sync_release: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (s_q.f_state == arb_host_pkg::F_HOLD && !interrupt_strobe_i)
      |=> !s_q.sync && !s_q.grant_en)
    else $error("slave-sync not released");

  a_grant_hold: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    (!s_q.grant_en && !level_set_i) |=> !s_q.grant_en)
    else $error("level grants enabled without authorisation");

  a_tail_wait: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $fell(s_q.strobe) |-> s_q.busy [*8] ##11 s_q.busy)
    else $error("bus-busy released too soon");

endmodule : arb_host

// [sim/arb_model.sv]
// behavioural arbitrator model that hands out the level grant
`timescale 1ns/1ps
module arb_model #(
  parameter int TIMEOUT_CYC = 1250
) (
  input  wire logic       clock_i,
  input  wire logic       rst_n_i,
  input  wire logic       level_request_i,
  input  wire logic       selection_acknowledge_i,
  input  wire logic       level_grant_enable_i,
  input  wire logic [7:0] grant_delay_i,
  output logic            level_grant_o
);
  int quiet_q;
  int wait_q;
  int held_q;

  always @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_grant_o <= 1'b0;
      quiet_q       <= 0;
      wait_q        <= 0;
      held_q        <= 0;
    end else if (selection_acknowledge_i === 1'b1) begin
      // no grant and no arbitration while acknowledge stands
      level_grant_o <= 1'b0;
      quiet_q       <= 0;
    end else if (level_grant_o) begin
      held_q <= held_q + 1;
      if (held_q >= TIMEOUT_CYC) begin
        level_grant_o <= 1'b0;
      end
    end else begin
      held_q <= 0;
      wait_q <= (level_request_i === 1'b1) ? wait_q + 1 : 0;
      if (quiet_q < 1000) begin
        quiet_q <= quiet_q + 1;
      end
      // quiet time in whole clocks; a lone grant halts arbitration
      if (level_request_i === 1'b1 && level_grant_enable_i === 1'b1 &&
          wait_q >= int'(grant_delay_i) &&
          quiet_q >= int'(arb_host_pkg::DESKEW_CYC)) begin
        level_grant_o <= 1'b1;
      end
    end
  end
endmodule : arb_model

// [sim/priority_interrupt_arbitration_bench.sv]
// self-checking bench: host master and fielder against the arbitrator model
`timescale 1ns/1ps
module priority_interrupt_arbitration_bench;
  localparam logic [15:0] VEC_A = 16'ha5c3;
  localparam logic [15:0] VEC_B = 16'h5a3c;
  localparam logic [15:0] DESKEW_EXP = 16'(arb_host_pkg::DESKEW_CYC + 1);
  localparam logic [15:0] DROP_EXP = 16'(arb_host_pkg::DESKEW_CYC);
  logic        clock_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        irq_start_i = 1'b0;
  logic [15:0] irq_vector_i = 16'h0000;
  logic        level_set_i = 1'b0;
  logic        other_busy = 1'b0;
  logic        other_sync = 1'b0;
  logic [7:0]  grant_delay = 8'h00;
  logic irq_busy_o, irq_done_o, fielded_valid_o, level_grant_enable_o;
  logic level_request_o, level_request_oe_n_o, selection_acknowledge_o;
  logic selection_acknowledge_oe_n_o, bus_busy_o, bus_busy_oe_n_o;
  logic interrupt_strobe_o, interrupt_strobe_oe_n_o, slave_sync_o;
  logic slave_sync_oe_n_o, data_oe_n_o, level_grant_i;
  logic [15:0] fielded_vector_o, data_o;
  // open-drain lines read negated when nobody drives them
  wire level_request_i = level_request_o & ~level_request_oe_n_o;
  wire selection_acknowledge_i =
    selection_acknowledge_o & ~selection_acknowledge_oe_n_o;
  wire bus_busy_i = (bus_busy_o & ~bus_busy_oe_n_o) | other_busy;
  wire interrupt_strobe_i = interrupt_strobe_o & ~interrupt_strobe_oe_n_o;
  wire slave_sync_i = (slave_sync_o & ~slave_sync_oe_n_o) | other_sync;
  wire [15:0] data_i = data_oe_n_o ? 16'h0000 : data_o;
  int miscompares = 0;
  int num_checks = 0;

  always #2 clock_i = ~clock_i;

  arb_host dut (.clock_i, .rst_n_i, .irq_start_i, .irq_vector_i, .irq_busy_o,
    .irq_done_o, .level_set_i, .fielded_vector_o, .fielded_valid_o,
    .level_grant_enable_o, .level_grant_i, .level_request_i, .level_request_o,
    .level_request_oe_n_o, .selection_acknowledge_i, .selection_acknowledge_o,
    .selection_acknowledge_oe_n_o, .bus_busy_i, .bus_busy_o, .bus_busy_oe_n_o,
    .interrupt_strobe_i, .interrupt_strobe_o, .interrupt_strobe_oe_n_o,
    .slave_sync_i, .slave_sync_o, .slave_sync_oe_n_o, .data_i, .data_o,
    .data_oe_n_o);

  arb_model arbiter (.clock_i, .rst_n_i, .level_request_i,
    .selection_acknowledge_i, .level_grant_enable_i(level_grant_enable_o),
    .grant_delay_i(grant_delay), .level_grant_o(level_grant_i));

  task automatic check_vec(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_vec

  task automatic check_bit(input logic got, input logic exp);
    check_vec({15'h0, got}, {15'h0, exp});
  endtask : check_bit

  task automatic give_verdict();
    if (miscompares == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
  endtask : tick

  task automatic start_irq(input logic [15:0] vec);
    irq_start_i  <= 1'b1;
    irq_vector_i <= vec;
    tick(1);
    irq_start_i  <= 1'b0;
  endtask : start_irq

  // done pulse when sel is set, else the fielded-vector pulse
  task automatic wait_pulse(input bit sel);
    int n = 0;
    while ((sel ? irq_done_o : fielded_valid_o) !== 1'b1 && n < 600) begin
      tick(1);
      n++;
    end
    check_bit(sel ? irq_done_o : fielded_valid_o, 1'b1);
  endtask : wait_pulse

  task automatic authorise();
    level_set_i <= 1'b1;
    tick(1);
    level_set_i <= 1'b0;
    tick(2);
  endtask : authorise

  task automatic t_basic();
    start_irq(VEC_A);
    tick(3);
    start_irq(VEC_B);
    wait_pulse(1'b0);
    check_vec(fielded_vector_o, VEC_A);
    check_bit(level_grant_enable_o, 1'b0);
    level_set_i <= 1'b1;
    tick(1);
    level_set_i <= 1'b0;
    wait_pulse(1'b1);
    check_bit(level_grant_enable_o, 1'b0);
    tick(4);
    check_bit(irq_busy_o, 1'b0);
    authorise();
    check_bit(level_grant_enable_o, 1'b1);
  endtask : t_basic

  task automatic t_hold();
    other_busy <= 1'b1;
    other_sync <= 1'b1;
    start_irq(VEC_B);
    tick(60);
    check_bit(selection_acknowledge_i, 1'b1);
    check_bit(bus_busy_o, 1'b0);
    other_busy <= 1'b0;
    tick(30);
    check_bit(bus_busy_o, 1'b1);
    check_bit(interrupt_strobe_i, 1'b0);
    check_bit(selection_acknowledge_i, 1'b1);
    other_sync <= 1'b0;
    wait_pulse(1'b0);
    check_vec(fielded_vector_o, VEC_B);
    wait_pulse(1'b1);
    authorise();
  endtask : t_hold

  task automatic t_back();
    grant_delay <= 8'h28;
    start_irq(VEC_A);
    wait_pulse(1'b1);
    start_irq(VEC_B);
    tick(80);
    check_bit(level_grant_i, 1'b0);
    check_bit(level_request_i, 1'b1);
    authorise();
    wait_pulse(1'b0);
    check_vec(fielded_vector_o, VEC_B);
    wait_pulse(1'b1);
    authorise();
  endtask : t_back

  // wire-level ordering seen at every edge
  bit p_s, p_a, p_b, p_y, p_w, sent;
  int since_strobe, since_drop;
  always @(posedge clock_i) begin
    bit s, a, b;
    s = (interrupt_strobe_i === 1'b1);
    a = (selection_acknowledge_i === 1'b1);
    b = (bus_busy_o === 1'b1 && bus_busy_oe_n_o === 1'b0);
    since_strobe++;
    since_drop++;
    if (rst_n_i === 1'b1) begin
      if (s && !p_s) begin
        check_bit(data_oe_n_o, 1'b0);
        check_bit(p_y, 1'b0);
        since_strobe = 0;
        sent = 1'b1;
      end
      if (p_s && !s) begin
        check_bit(data_oe_n_o, 1'b1);
        since_drop = 0;
      end
      if (fielded_valid_o === 1'b1) begin
        check_vec(16'(since_strobe), DESKEW_EXP);
      end
      if (a && !p_a) begin
        check_bit(level_request_i, 1'b0);
      end
      if (p_a && !a) begin
        check_bit(sent, 1'b1);
        check_bit(level_grant_i, 1'b0);
      end
      if (b && !p_b) begin
        check_bit(p_w, 1'b0);
      end
      if (p_b && !b) begin
        check_bit(selection_acknowledge_i, 1'b0);
        check_vec(16'(since_drop), DROP_EXP);
        sent = 1'b0;
      end
    end
    p_s = s;
    p_a = a;
    p_b = b;
    p_y = (slave_sync_i === 1'b1);
    p_w = (bus_busy_i === 1'b1);
  end

  initial begin
    tick(5);
    check_vec({8'h00, level_request_o, selection_acknowledge_o, bus_busy_o,
      interrupt_strobe_o, slave_sync_o, irq_busy_o, irq_done_o,
      fielded_valid_o}, 16'h0000);
    check_vec({9'h000, level_request_oe_n_o, selection_acknowledge_oe_n_o,
      bus_busy_oe_n_o, interrupt_strobe_oe_n_o, slave_sync_oe_n_o,
      data_oe_n_o, level_grant_enable_o}, 16'h007f);
    check_vec(data_o, 16'h0000);
    tick(1);
    rst_n_i <= 1'b1;
    tick(1);
    t_basic();
    t_hold();
    t_back();
    give_verdict();
  end

  initial begin
    tick(20000);
    miscompares++;
    give_verdict();
  end
endmodule : priority_interrupt_arbitration_bench
